// ===== bench/hpm_host_model.sv
/* external host driving the port strobes.
   assumes the port's registered read drive. */
`timescale 1ns/100ps
module hpm_host_model (
  input wire core_clk,
  input wire [15:0] port_bus_out,
  input wire [15:0] port_bus_oe,
  output reg read_strobe_n = 1'b1,
  output reg write_strobe_n = 1'b1,
  output reg chip_select_n = 1'b1,
  output reg port_sel_hi = 1'b0,
  output reg port_sel_lo = 1'b0,
  output reg [15:0] port_bus_in = 16'h0000
);
  // ==========================================
  // held strobes, bus driven on writes
  task access(input reg is_wr, input reg [1:0] sel, input reg [15:0] d, output reg [15:0] q);
    begin
      @(posedge core_clk);
      #1 {port_sel_hi, port_sel_lo} = sel;
      port_bus_in = is_wr ? d : ~port_bus_in;
      chip_select_n = 1'b0;
      read_strobe_n = is_wr;
      write_strobe_n = !is_wr;
      repeat (6) @(posedge core_clk);
      #1 q = (port_bus_oe === 16'hFFFF) ? port_bus_out : ~port_bus_out;
      read_strobe_n = 1'b1;
      write_strobe_n = 1'b1;
      chip_select_n = 1'b1;
      port_bus_in = ~port_bus_in;
      repeat (5) @(posedge core_clk);
    end
  endtask
endmodule

// ===== bench/hpm_port_sva.sv
/* pin checker for the host parallel port.
   assumes bound to every hpm_port instance. */
`timescale 1ns/100ps
module hpm_port_sva (
  input wire core_clk,
  input wire resetn,
  input wire read_strobe_n,
  input wire write_strobe_n,
  input wire chip_select_n,
  input wire port_sel_hi,
  input wire port_sel_lo,
  input wire [15:0] port_bus_oe,
  input wire [5:0] ctrl_test_oe,
  input wire mailbox_irq_out,
  input wire cpu_mbx_wr,
  input wire cpu_mbx_full,
  input wire port_enabled
);
  // ==========================================
  // cycles since the read strobe was low
  reg [3:0] rd_hi_cnt;
  wire quiet = ctrl_test_oe == 6'h00;
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) rd_hi_cnt <= 4'h0;
    else if (!read_strobe_n) rd_hi_cnt <= 4'h0;
    else if (rd_hi_cnt != 4'hF) rd_hi_cnt <= rd_hi_cnt + 4'h1;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence s_rd_low; (!read_strobe_n && !chip_select_n)[*6]; endsequence
  sequence s_mbx_end; $rose(write_strobe_n) && {port_sel_hi, port_sel_lo} == 2'h1 && port_enabled && quiet; endsequence
  property p_rd_drive; s_rd_low ##0 (port_enabled && quiet) |-> port_bus_oe == 16'hFFFF; endproperty
  property p_idle; (read_strobe_n && quiet)[*6] |-> port_bus_oe == 16'h0000; endproperty
  property p_rd_end; $rose(read_strobe_n) && quiet |-> ##[1:5] port_bus_oe == 16'h0000; endproperty
  property p_test; ctrl_test_oe != 6'h00 |-> ctrl_test_oe == 6'h3F && port_bus_oe[7:0] == 8'h00; endproperty
  property p_irq_set; cpu_mbx_wr |=> mailbox_irq_out; endproperty
  property p_irq_cause; $rose(mailbox_irq_out) |-> $past(cpu_mbx_wr); endproperty
  property p_irq_hold; mailbox_irq_out && rd_hi_cnt > 4'h8 |=> mailbox_irq_out; endproperty
  property p_mbx_in; s_mbx_end |-> ##[1:8] cpu_mbx_full; endproperty
  property p_en_keep; port_enabled |=> port_enabled; endproperty
  a_rd_drive: assert property (p_rd_drive) else $error("read not driven");
  a_idle: assert property (p_idle) else $error("bus driven while idle");
  a_rd_end: assert property (p_rd_end) else $error("bus held after read");
  a_test: assert property (p_test) else $error("test drive wrong");
  a_irq_set: assert property (p_irq_set) else $error("irq not set");
  a_irq_cause: assert property (p_irq_cause) else $error("irq without write");
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped early");
  a_mbx_in: assert property (p_mbx_in) else $error("mailbox not full");
  a_en_keep: assert property (p_en_keep) else $error("enable lost");
endmodule
bind hpm_port hpm_port_sva chk (.core_clk(core_clk), .resetn(resetn), .read_strobe_n(read_strobe_n),
  .write_strobe_n(write_strobe_n), .chip_select_n(chip_select_n), .port_sel_hi(port_sel_hi),
  .port_sel_lo(port_sel_lo), .port_bus_oe(port_bus_oe), .ctrl_test_oe(ctrl_test_oe),
  .mailbox_irq_out(mailbox_irq_out), .cpu_mbx_wr(cpu_mbx_wr), .cpu_mbx_full(cpu_mbx_full),
  .port_enabled(port_enabled));

// ===== bench/hpm_port_tb.sv
/* self-checking bench for the host parallel port.
   assumes the host model and checker files. */
`timescale 1ns/100ps
`include "hpm_defs.vh"
module hpm_port_tb;
  reg core_clk = 1'b0;
  reg resetn = 1'b0;
  reg [1:0] boot_sel = 2'h0;
  reg mwr = 1'b0;
  reg mrd = 1'b0;
  reg [15:0] mwd = 16'h0000;
  reg [15:0] q;
  wire rd_n, wr_n, cs_n, shi, slo, irq, full, en;
  wire [15:0] b_in, b_out, b_oe, m_rd;
  wire [5:0] t_out, t_oe;
  integer mismatches = 0;
  integer checks_done = 0;
  integer i;
  always #50 core_clk = ~core_clk;
  hpm_port uut (.core_clk(core_clk), .resetn(resetn), .boot_sel(boot_sel), .read_strobe_n(rd_n),
    .write_strobe_n(wr_n), .chip_select_n(cs_n), .port_sel_hi(shi), .port_sel_lo(slo), .port_bus_in(b_in),
    .port_bus_out(b_out), .port_bus_oe(b_oe), .ctrl_test_out(t_out), .ctrl_test_oe(t_oe),
    .mailbox_irq_out(irq), .cpu_mbx_wr(mwr), .cpu_mbx_wdata(mwd), .cpu_mbx_rd(mrd),
    .cpu_mbx_rdata(m_rd), .cpu_mbx_full(full), .port_enabled(en));
  hpm_host_model host (.core_clk(core_clk), .port_bus_out(b_out), .port_bus_oe(b_oe), .read_strobe_n(rd_n),
    .write_strobe_n(wr_n), .chip_select_n(cs_n), .port_sel_hi(shi), .port_sel_lo(slo), .port_bus_in(b_in));
  // ==========================================
  // compare and verdict
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  // local processor mailbox pulse
  task cpu_pulse(input reg wr, input reg [15:0] d);
    begin
      @(posedge core_clk);
      #1 mwr = wr;
      mrd = !wr;
      mwd = d;
      @(posedge core_clk);
      #1 mwr = 1'b0;
      mrd = 1'b0;
      repeat (2) @(posedge core_clk);
    end
  endtask
  // watchdog
  initial begin
    #(40000 * 100);
    mismatches = mismatches + 1;
    final_report;
  end
  // ==========================================
  // main sequence
  initial begin
    repeat (2) @(posedge core_clk);
    #1 resetn = 1'b1;
    repeat (100) @(posedge core_clk);
    chk({10'h0, t_oe}, 16'h003F);
    chk(b_oe, 16'hFF00);
    chk({10'h0, t_out}, 16'h0000);
    host.access(1'b1, `HPM_SEL_ADDRESS, 16'h0040, q);
    repeat (`HPM_TEST_CYCLES) @(posedge core_clk);
    chk({15'h0, en}, 16'h0001);
    chk({10'h0, t_oe}, 16'h0000);
    host.access(1'b0, `HPM_SEL_ADDRESS, 16'h0000, q);
    chk(q, 16'h0000);
    host.access(1'b1, `HPM_SEL_ADDRESS, 16'h0020, q);
    for (i = 0; i < 3; i = i + 1) host.access(1'b1, `HPM_SEL_DATA, 16'hA5C0 + i[15:0], q);
    host.access(1'b1, `HPM_SEL_STATUS, 16'hFFFF, q);
    host.access(1'b0, `HPM_SEL_STATUS, 16'h0000, q);
    chk({12'h0, q[3:0]}, 16'h0008);
    host.access(1'b0, `HPM_SEL_ADDRESS, 16'h0000, q);
    chk(q, 16'h0026);
    host.access(1'b1, `HPM_SEL_ADDRESS, 16'h0020, q);
    for (i = 0; i < 3; i = i + 1) begin
      host.access(1'b0, `HPM_SEL_DATA, 16'h0000, q);
      chk(q, 16'hA5C0 + i[15:0]);
    end
    host.access(1'b1, `HPM_SEL_MAILBOX, 16'h1234, q);
    chk({15'h0, full}, 16'h0001);
    chk(m_rd, 16'h1234);
    cpu_pulse(1'b0, 16'h0000);
    chk({15'h0, full}, 16'h0000);
    cpu_pulse(1'b1, 16'hBEEF);
    chk({15'h0, irq}, 16'h0001);
    host.access(1'b0, `HPM_SEL_STATUS, 16'h0000, q);
    chk({15'h0, q[0]}, 16'h0001);
    host.access(1'b0, `HPM_SEL_MAILBOX, 16'h0000, q);
    chk(q, 16'hBEEF);
    repeat (4) @(posedge core_clk);
    chk({15'h0, irq}, 16'h0000);
    // second reset with other straps
    #1 resetn = 1'b0;
    boot_sel = 2'h1;
    repeat (2) @(posedge core_clk);
    #1 resetn = 1'b1;
    repeat (10) @(posedge core_clk);
    chk({15'h0, en}, 16'h0000);
    final_report;
  end
endmodule

// ===== rtl/hpm_defs.vh
/*
  constants for the host parallel port mailbox block: port register
  selects, reset values and timing counts.
  assumes a 10 MHz core clock.
*/
`ifndef HPM_DEFS_VH
`define HPM_DEFS_VH
// ==========================================
// port register selects
`define HPM_SEL_DATA 2'h0
`define HPM_SEL_MAILBOX 2'h1
`define HPM_SEL_ADDRESS 2'h2
`define HPM_SEL_STATUS 2'h3
// ==========================================
// reset values
`define HPM_MAILBOX_RST 16'h0000
`define HPM_ADDRESS_RST 16'h0000
// ==========================================
// status bit positions
`define HPM_ST_OUT_FULL 0
`define HPM_ST_IN_FULL 1
`define HPM_ST_TEST_MODE 2
`define HPM_ST_ENABLED 3
// ==========================================
// timing
`define HPM_CLK_PERIOD_NS 100
`define HPM_TEST_WINDOW_MS 3
// 3 ms at 100 ns per cycle, sized to the window counter
`define HPM_TEST_CYCLES 23'h007530
// ==========================================
// memory
`define HPM_MEM_ADDR_W 13
`endif

// ===== rtl/hpm_memory.v
/*
  internal word memory reached through the port data window.
  assumes a single clock; read data appear one cycle after the address.
*/
`timescale 1ns/100ps
`include "hpm_defs.vh"
module hpm_memory (
  input wire core_clk,
  input wire wr_en,
  input wire [`HPM_MEM_ADDR_W-1:0] addr,
  input wire [15:0] wr_data,
  output reg [15:0] rd_data
);
  reg [15:0] mem [0:(1<<`HPM_MEM_ADDR_W)-1];

  // ==========================================
  // synchronous write, registered read
  always @(posedge core_clk) begin
    if (wr_en) begin
      mem[addr] <= wr_data;
    end
    rd_data <= mem[addr];
  end
endmodule

// ===== rtl/hpm_port.v
/*
  host parallel port with mailbox: external host reaches internal memory,
  a bidirectional mailbox, an address pointer and a status word.
  assumes host strobes, select and data pins are asynchronous to core_clk;
  the local processor side is on core_clk.
*/
`timescale 1ns/100ps
`include "hpm_defs.vh"
module hpm_port (
  input wire core_clk,
  input wire resetn,
  input wire [1:0] boot_sel,
  input wire read_strobe_n,
  input wire write_strobe_n,
  input wire chip_select_n,
  input wire port_sel_hi,
  input wire port_sel_lo,
  input wire [15:0] port_bus_in,
  output reg [15:0] port_bus_out,
  output reg [15:0] port_bus_oe,
  output reg [5:0] ctrl_test_out,
  output reg [5:0] ctrl_test_oe,
  output reg mailbox_irq_out,
  input wire cpu_mbx_wr,
  input wire [15:0] cpu_mbx_wdata,
  input wire cpu_mbx_rd,
  output reg [15:0] cpu_mbx_rdata,
  output reg cpu_mbx_full,
  output reg port_enabled
);
  localparam ST_IDLE = 3'b001;
  localparam ST_READ = 3'b010;
  localparam ST_WRITE = 3'b100;
  localparam [22:0] TEST_CYCLES = `HPM_TEST_CYCLES;

  reg rst_s1;
  reg rst_s2;
  reg [20:0] sync1;
  reg [20:0] sync2;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [1:0] sel_q;
  reg [15:0] wdata_q;
  reg [15:0] addr_ptr;
  reg [15:0] mbx_out;
  reg [15:0] mbx_in;
  reg in_full;
  reg [1:0] boot_s1;
  reg [1:0] boot_s2;
  reg boot_done;
  reg test_mode;
  reg [22:0] test_cnt;
  reg mem_wr;
  wire [15:0] mem_rdata;
  wire rd_n;
  wire wr_n;
  wire cs_n;
  wire [1:0] sel;
  wire [15:0] bus_in;
  wire rd_act;
  wire wr_act;
  wire rd_end;
  wire wr_end;
  wire [15:0] status_word;
  wire host_mbx_rd;

  // ==========================================
  // reset release through two flip-flops
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end

  // ==========================================
  // pin synchronisers, two stages each
  always @(posedge core_clk or negedge rst_s2) begin
    if (!rst_s2) begin
      sync1 <= 21'h1C0000;
      sync2 <= 21'h1C0000;
    end else begin
      sync1 <= {read_strobe_n, write_strobe_n, chip_select_n, port_sel_hi, port_sel_lo, port_bus_in};
      sync2 <= sync1;
    end
  end
  assign rd_n = sync2[20];
  assign wr_n = sync2[19];
  assign cs_n = sync2[18];
  assign sel = sync2[17:16];
  assign bus_in = sync2[15:0];
  assign rd_act = port_enabled & ~test_mode & ~cs_n & ~rd_n;
  assign wr_act = port_enabled & ~test_mode & ~cs_n & ~wr_n;
  assign rd_end = (state == ST_READ) & ~rd_act;
  assign wr_end = (state == ST_WRITE) & ~wr_act;
  assign host_mbx_rd = rd_end & (sel_q == `HPM_SEL_MAILBOX);

  // ==========================================
  // strap synchroniser, free running so it is full when reset lifts
  always @(posedge core_clk) begin
    boot_s1 <= boot_sel;
    boot_s2 <= boot_s1;
  end

  // ==========================================
  // boot select capture and startup test window
  always @(posedge core_clk or negedge rst_s2) begin
    if (!rst_s2) begin
      boot_done <= 1'b0;
      port_enabled <= 1'b0;
      test_mode <= 1'b1;
      test_cnt <= 23'h000000;
    end else begin
      if (!boot_done) begin
        boot_done <= 1'b1;
        port_enabled <= (boot_s2 == 2'h0);
      end
      if (test_mode) begin
        if (test_cnt == TEST_CYCLES - 23'h000001) begin
          test_mode <= 1'b0;
        end else begin
          test_cnt <= test_cnt + 23'h000001;
        end
      end
    end
  end

  // ==========================================
  // access state machine
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (rd_act) begin
          next_state = ST_READ;
        end else if (wr_act) begin
          next_state = ST_WRITE;
        end
      end
      ST_READ: begin
        if (!rd_act) begin
          next_state = ST_IDLE;
        end
      end
      ST_WRITE: begin
        if (!wr_act) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  assign status_word = {12'h000, port_enabled, test_mode, in_full, mailbox_irq_out};

  // ==========================================
  // registers, pointer, mailboxes
  always @(posedge core_clk or negedge rst_s2) begin
    if (!rst_s2) begin
      state <= ST_IDLE;
      sel_q <= 2'h0;
      wdata_q <= 16'h0000;
      addr_ptr <= `HPM_ADDRESS_RST;
      mbx_out <= `HPM_MAILBOX_RST;
      mbx_in <= `HPM_MAILBOX_RST;
      in_full <= 1'b0;
      mailbox_irq_out <= 1'b0;
      mem_wr <= 1'b0;
    end else begin
      state <= next_state;
      mem_wr <= 1'b0;
      // latch select and data while strobe low
      if (rd_act | wr_act) begin
        sel_q <= sel;
        wdata_q <= bus_in;
      end
      if (wr_end) begin
        case (sel_q)
          `HPM_SEL_DATA: mem_wr <= 1'b1;
          `HPM_SEL_MAILBOX: mbx_in <= wdata_q;
          `HPM_SEL_ADDRESS: addr_ptr <= wdata_q;
          default: mbx_in <= mbx_in;
        endcase
      end
      if ((rd_end & (sel_q == `HPM_SEL_DATA)) | mem_wr) begin
        addr_ptr <= addr_ptr + 16'h0002;
      end
      if (wr_end & (sel_q == `HPM_SEL_MAILBOX)) begin
        in_full <= 1'b1;
      end else if (cpu_mbx_rd) begin
        in_full <= 1'b0;
      end
      // local write sets, host read clears
      if (cpu_mbx_wr) begin
        mbx_out <= cpu_mbx_wdata;
        mailbox_irq_out <= 1'b1;
      end else if (host_mbx_rd) begin
        mailbox_irq_out <= 1'b0;
      end
    end
  end

  // ==========================================
  // pin drive and local read data
  always @(posedge core_clk or negedge rst_s2) begin
    if (!rst_s2) begin
      port_bus_out <= 16'h0000;
      port_bus_oe <= 16'h0000;
      ctrl_test_out <= 6'h00;
      ctrl_test_oe <= 6'h00;
      cpu_mbx_rdata <= 16'h0000;
      cpu_mbx_full <= 1'b0;
    end else begin
      cpu_mbx_rdata <= mbx_in;
      cpu_mbx_full <= in_full;
      // upper data and control as outputs
      ctrl_test_oe <= {6{test_mode}};
      ctrl_test_out <= 6'h00;
      if (test_mode) begin
        port_bus_oe <= 16'hFF00;
        port_bus_out <= 16'h0000;
      end else if (state == ST_READ && rd_act) begin
        port_bus_oe <= 16'hFFFF;
        case (sel_q)
          `HPM_SEL_DATA: port_bus_out <= mem_rdata;
          `HPM_SEL_MAILBOX: port_bus_out <= mbx_out;
          `HPM_SEL_ADDRESS: port_bus_out <= addr_ptr;
          default: port_bus_out <= status_word;
        endcase
      end else begin
        port_bus_oe <= 16'h0000;
        port_bus_out <= 16'h0000;
      end
    end
  end

  // ==========================================
  // internal memory, word addressed by byte pointer
  hpm_memory u_mem (
    .core_clk(core_clk),
    .wr_en(mem_wr),
    .addr(addr_ptr[`HPM_MEM_ADDR_W:1]),
    .wr_data(wdata_q),
    .rd_data(mem_rdata)
  );
endmodule
